// ==== verilog/nvc_ctrl.sv ====
// Nested vector controller: pending/active tracking, priority resolution,
// hardware stacking sequence, tail-chaining and late arrival, boot fetch.
// Assumes the core and vector memory answer fetches with vec_ready.
module nvc_ctrl #(
  parameter int NMI_PINS = 8,
  parameter int NMI_SEL_W = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [nvc_pkg::N_IRQ-1:0] fixed_irq,
  input wire logic [nvc_pkg::DMA_GRP-1:0] dma_terminal_out_low_group,
  input wire logic [nvc_pkg::DMA_GRP-1:0] dma_terminal_out_high_group,
  input wire logic [nvc_pkg::N_IRQ-1:0] array_irq,
  input wire logic [2*nvc_pkg::N_IRQ-1:0] source_sel,
  input wire logic [nvc_pkg::N_IRQ-1:0] irq_enable,
  input wire logic [nvc_pkg::N_IRQ*nvc_pkg::PRIO_W-1:0] irq_priority,
  input wire logic [nvc_pkg::N_SYS*nvc_pkg::PRIO_W-1:0] sys_priority,
  input wire logic [2:0] fault_enable,
  input wire logic [1:0] priority_group,
  input wire logic [nvc_pkg::PRIO_W-1:0] base_priority_mask,
  input wire logic primask,
  input wire logic faultmask,
  input wire logic [NMI_PINS-1:0] nmi_pins,
  input wire logic [NMI_SEL_W-1:0] nmi_pin_sel,
  input wire logic nmi_connect,
  input wire logic nonexec_fetch,
  input wire logic bus_error,
  input wire logic invalid_instr,
  input wire logic service_call,
  input wire logic debug_monitor,
  input wire logic deferred_service_request,
  input wire logic system_tick_timer,
  input wire logic exc_return,
  input wire logic vec_ready,
  input wire logic [31:0] vec_data,
  output logic vec_fetch_q,
  output logic [nvc_pkg::AW-1:0] vec_addr_q,
  output logic sp_load_q,
  output logic [31:0] main_stack_pointer_q,
  output logic handler_start_q,
  output logic [31:0] handler_addr_q,
  output logic [nvc_pkg::IDX_W-1:0] exc_num_q,
  output logic stacking_q,
  output logic unstacking_q,
  output logic [nvc_pkg::N_EXC-1:0] pending_q,
  output logic [nvc_pkg::N_EXC-1:0] active_q,
  output logic [nvc_pkg::EXT_W-1:0] running_level_q
);
  localparam int NE = nvc_pkg::N_EXC;
  localparam int EW = nvc_pkg::EXT_W;
  localparam int PW = nvc_pkg::PRIO_W;
  localparam logic [NE-1:0] SYS_IMPL = 48'h0000_0000_D87C;

  if (NMI_PINS < 1 || NMI_PINS > (1 << NMI_SEL_W)) begin : g_bad_nmi
    $error("nvc_ctrl: NMI_PINS does not fit NMI_SEL_W");
  end

  // Extended level of a programmable value
  function automatic logic [EW-1:0] prog_level(input logic [PW-1:0] p);
    prog_level = nvc_pkg::LVL_PROG_BASE + EW'(p);
  endfunction

  nvc_pkg::nvc_state_t state_q, state_d;
  logic [3:0] cnt_q;
  logic [nvc_pkg::IDX_W-1:0] taken_q;
  logic [nvc_pkg::N_IRQ-1:0] src_prev_q;
  logic nmi_prev_q;

  wire logic [nvc_pkg::N_IRQ-1:0] src;
  wire logic [NE*EW-1:0] full_lvl;
  wire logic [NE*EW-1:0] grp_lvl;
  wire logic [NE-1:0] take_ok;
  wire logic [NE-1:0] eligible;
  wire logic [NE-1:0] pend_set;
  wire logic [NE-1:0] pend_clr;
  wire logic [PW-1:0] grp_mask;
  wire logic [EW-1:0] run_grp;
  wire logic [nvc_pkg::IDX_W-1:0] win_idx;
  wire logic [nvc_pkg::IDX_W-1:0] act_idx;
  wire logic win_found;
  wire logic act_found;
  wire logic nmi_level;
  wire logic inv_state;
  wire logic [2:0] fault_req;
  wire logic [2:0] fault_escalate;
  wire logic entry_done;
  wire logic stack_end;
  wire logic unstack_end;

  nvc_src_sel #(
    .N(nvc_pkg::N_IRQ)
  ) u_src (
    .fixed_irq(fixed_irq),
    .dma_terminal_out_low_group(dma_terminal_out_low_group),
    .dma_terminal_out_high_group(dma_terminal_out_high_group),
    .array_irq(array_irq),
    .source_sel(source_sel),
    .src(src)
  );

  // Only the upper PRIO_W minus priority_group bits form the preempting group level
  assign grp_mask = PW'(3'h7 << priority_group);

  for (genvar i = 0; i < NE; i++) begin : g_exc
    wire logic [PW-1:0] raw;
    wire logic en;
    wire logic masked;
    if (i < nvc_pkg::N_SYS) begin : g_sys
      assign raw = sys_priority[i*PW +: PW];
      assign en = (i >= 4 && i <= 6) ? fault_enable[(i >= 4) ? i - 4 : 0] : SYS_IMPL[i];
    end else begin : g_irq
      // Levels are read live so software may retune them at any time
      assign raw = irq_priority[(i-16)*PW +: PW];
      assign en = irq_enable[i-16];
    end
    if (i == 1) begin : g_lv_reset
      assign full_lvl[i*EW +: EW] = nvc_pkg::LVL_RESET;
      assign grp_lvl[i*EW +: EW] = nvc_pkg::LVL_RESET;
    end else if (i == 2) begin : g_lv_nmi
      assign full_lvl[i*EW +: EW] = nvc_pkg::LVL_NMI;
      assign grp_lvl[i*EW +: EW] = nvc_pkg::LVL_NMI;
    end else if (i == 3) begin : g_lv_hard
      assign full_lvl[i*EW +: EW] = nvc_pkg::LVL_HARD;
      assign grp_lvl[i*EW +: EW] = nvc_pkg::LVL_HARD;
    end else begin : g_lv_prog
      assign full_lvl[i*EW +: EW] = prog_level(raw);
      assign grp_lvl[i*EW +: EW] = prog_level(raw & grp_mask);
    end
    assign masked = faultmask ? (i != 2) :
                    primask ? (i != 2 && i != 3) :
                    (base_priority_mask != '0 && i > 3 && raw >= base_priority_mask);
    assign take_ok[i] = en && !masked && (grp_lvl[i*EW +: EW] < run_grp);
  end

  assign eligible = pending_q & take_ok;

  // Full level picks among eligible; ties fall to the lower number
  nvc_prio_arb #(
    .N(NE),
    .W(EW),
    .IW(nvc_pkg::IDX_W)
  ) u_win (
    .req(eligible),
    .prio(full_lvl),
    .found(win_found),
    .idx(win_idx),
    .level()
  );

  // Running group level comes from the innermost active handler
  nvc_prio_arb #(
    .N(NE),
    .W(EW),
    .IW(nvc_pkg::IDX_W)
  ) u_act (
    .req(active_q),
    .prio(grp_lvl),
    .found(act_found),
    .idx(act_idx),
    .level(run_grp)
  );

  assign nmi_level = nmi_connect && nmi_pins[nmi_pin_sel];
  assign entry_done = (state_q == nvc_pkg::ST_FETCH) && vec_ready;
  // An even entry would leave the compact state
  assign inv_state = entry_done && !vec_data[0];
  assign fault_req = {invalid_instr | inv_state, bus_error, nonexec_fetch};
  assign fault_escalate = fault_req & ~take_ok[6:4];

  assign pend_set[0] = 1'b0;
  assign pend_set[1] = 1'b0;
  assign pend_set[2] = nmi_level && !nmi_prev_q;
  assign pend_set[3] = |fault_escalate;
  assign pend_set[6:4] = fault_req & take_ok[6:4];
  assign pend_set[10:7] = 4'h0;
  assign pend_set[11] = service_call;
  assign pend_set[12] = debug_monitor;
  assign pend_set[13] = 1'b0;
  assign pend_set[14] = deferred_service_request;
  assign pend_set[15] = system_tick_timer;
  assign pend_set[NE-1:16] = src & ~src_prev_q;
  assign pend_clr = entry_done ? (NE'(1) << taken_q) : '0;

  assign stack_end = (state_q == nvc_pkg::ST_STACK) && (cnt_q == nvc_pkg::STACK_WORDS - 4'h1);
  assign unstack_end = (state_q == nvc_pkg::ST_UNSTACK) &&
                       (cnt_q == nvc_pkg::STACK_WORDS - 4'h1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      nvc_pkg::ST_BOOT_SP: if (vec_ready) state_d = nvc_pkg::ST_BOOT_PC;
      nvc_pkg::ST_BOOT_PC: if (vec_ready) state_d = nvc_pkg::ST_RUN;
      nvc_pkg::ST_RUN: begin
        if (win_found) begin
          state_d = nvc_pkg::ST_STACK;
        end else if (exc_return && act_found) begin
          state_d = nvc_pkg::ST_EXIT;
        end
      end
      nvc_pkg::ST_STACK: begin
        if (stack_end) state_d = win_found ? nvc_pkg::ST_FETCH : nvc_pkg::ST_UNSTACK;
      end
      nvc_pkg::ST_FETCH: if (vec_ready) state_d = nvc_pkg::ST_RUN;
      // Chain straight into the next handler, skipping restore and save
      nvc_pkg::ST_EXIT: begin
        state_d = win_found ? nvc_pkg::ST_FETCH : nvc_pkg::ST_UNSTACK;
      end
      nvc_pkg::ST_UNSTACK: if (unstack_end) state_d = nvc_pkg::ST_RUN;
      default: state_d = nvc_pkg::ST_BOOT_SP;
    endcase
  end

  // Winner is re-chosen until stacking ends, so late arrivals go first
  wire logic take_now = stack_end || (state_q == nvc_pkg::ST_EXIT);
  wire logic [nvc_pkg::IDX_W-1:0] taken_d = take_now ? win_idx : taken_q;
  wire logic [nvc_pkg::AW-1:0] fetch_addr =
    nvc_pkg::AW'(taken_d) << nvc_pkg::VEC_ENTRY_SHIFT;
  wire logic [nvc_pkg::AW-1:0] vec_addr_d =
    (state_d == nvc_pkg::ST_BOOT_SP) ? nvc_pkg::VEC_SP_OFS :
    (state_d == nvc_pkg::ST_BOOT_PC) ? nvc_pkg::VEC_RESET_OFS : fetch_addr;
  wire logic [NE-1:0] act_clr =
    (state_q == nvc_pkg::ST_RUN && state_d == nvc_pkg::ST_EXIT) ? (NE'(1) << act_idx) : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= nvc_pkg::ST_BOOT_SP;
      cnt_q <= 4'h0;
      taken_q <= '0;
      src_prev_q <= '0;
      nmi_prev_q <= 1'b0;
      pending_q <= '0;
      active_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 4'h0 : cnt_q + 4'h1;
      taken_q <= taken_d;
      src_prev_q <= src;
      nmi_prev_q <= nmi_level;
      // A new event in the clearing cycle survives
      pending_q <= pend_set | (pending_q & ~pend_clr);
      active_q <= (active_q & ~act_clr) | pend_clr;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vec_fetch_q <= 1'b0;
      vec_addr_q <= nvc_pkg::VEC_SP_OFS;
      stacking_q <= 1'b0;
      unstacking_q <= 1'b0;
      running_level_q <= nvc_pkg::LVL_IDLE;
    end else begin
      vec_fetch_q <= (state_d == nvc_pkg::ST_BOOT_SP) || (state_d == nvc_pkg::ST_BOOT_PC) ||
                     (state_d == nvc_pkg::ST_FETCH);
      vec_addr_q <= vec_addr_d;
      stacking_q <= (state_d == nvc_pkg::ST_STACK);
      unstacking_q <= (state_d == nvc_pkg::ST_UNSTACK);
      running_level_q <= run_grp;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sp_load_q <= 1'b0;
      main_stack_pointer_q <= 32'h0000_0000;
      handler_start_q <= 1'b0;
      handler_addr_q <= 32'h0000_0000;
      exc_num_q <= '0;
    end else begin
      sp_load_q <= (state_q == nvc_pkg::ST_BOOT_SP) && vec_ready;
      if ((state_q == nvc_pkg::ST_BOOT_SP) && vec_ready) begin
        main_stack_pointer_q <= vec_data;
      end
      handler_start_q <= ((state_q == nvc_pkg::ST_BOOT_PC) && vec_ready) || entry_done;
      if (((state_q == nvc_pkg::ST_BOOT_PC) && vec_ready) || entry_done) begin
        handler_addr_q <= {vec_data[31:1], 1'b0};
        exc_num_q <= entry_done ? taken_q : nvc_pkg::EXC_RESET;
      end
    end
  end
endmodule // nvc_ctrl

// ==== verilog/nvc_pkg.sv ====
// Constants shared by the nested vector controller and its helpers.
// Assumes one 10 MHz clock domain with a synchronous active-high reset.
package nvc_pkg;
  localparam int N_SYS = 16;
  localparam int N_IRQ = 32;
  localparam int N_EXC = 48;
  localparam int DMA_GRP = 16;
  localparam int PRIO_W = 3;
  localparam int EXT_W = 4;
  localparam int IDX_W = 6;
  localparam int AW = 10;

  // Table offsets
  localparam logic [AW-1:0] VEC_SP_OFS = 10'h000;
  localparam logic [AW-1:0] VEC_RESET_OFS = 10'h004;
  localparam logic [AW-1:0] VEC_IRQ_BASE = 10'h040;
  localparam logic [AW-1:0] VEC_IRQ_LAST = 10'h3FC;
  localparam int VEC_ENTRY_SHIFT = 2;

  // Exception numbers
  localparam logic [IDX_W-1:0] EXC_RESET = 6'h01;
  localparam logic [IDX_W-1:0] EXC_NMI = 6'h02;
  localparam logic [IDX_W-1:0] EXC_HARD = 6'h03;
  localparam logic [IDX_W-1:0] EXC_MEM = 6'h04;
  localparam logic [IDX_W-1:0] EXC_BUS = 6'h05;
  localparam logic [IDX_W-1:0] EXC_USAGE = 6'h06;
  localparam logic [IDX_W-1:0] EXC_SVC = 6'h0B;
  localparam logic [IDX_W-1:0] EXC_DBG = 6'h0C;
  localparam logic [IDX_W-1:0] EXC_DEFERRED_SERVICE_REQUEST = 6'h0E;
  localparam logic [IDX_W-1:0] EXC_TICK = 6'h0F;
  localparam logic [IDX_W-1:0] EXC_IRQ0 = 6'h10;

  // Fixed levels -3/-2/-1 become 0/1/2; programmable p becomes p+3
  localparam logic [EXT_W-1:0] LVL_RESET = 4'h0;
  localparam logic [EXT_W-1:0] LVL_NMI = 4'h1;
  localparam logic [EXT_W-1:0] LVL_HARD = 4'h2;
  localparam logic [EXT_W-1:0] LVL_PROG_BASE = 4'h3;
  localparam logic [EXT_W-1:0] LVL_IDLE = 4'hF;

  // Source selector codes
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_DMA = 2'h1;
  localparam logic [1:0] SRC_ARRAY = 2'h2;

  // Words moved by the hardware stacking engine, one per cycle
  localparam logic [3:0] STACK_WORDS = 4'h8;

  typedef enum logic [2:0] {
    ST_BOOT_SP, ST_BOOT_PC, ST_RUN, ST_STACK, ST_FETCH, ST_EXIT, ST_UNSTACK
  } nvc_state_t;
endpackage

// ==== verilog/nvc_src_sel.sv ====
// Per-vector interrupt source selection.
// Assumes all request inputs are synchronous to the controller clock.
module nvc_src_sel #(
  parameter int N = 32
) (
  input wire logic [N-1:0] fixed_irq,
  input wire logic [nvc_pkg::DMA_GRP-1:0] dma_terminal_out_low_group,
  input wire logic [nvc_pkg::DMA_GRP-1:0] dma_terminal_out_high_group,
  input wire logic [N-1:0] array_irq,
  input wire logic [2*N-1:0] source_sel,
  output logic [N-1:0] src
);
  if (N > 2 * nvc_pkg::DMA_GRP || N < 1) begin : g_bad_n
    $error("nvc_src_sel: N out of range");
  end

  for (genvar n = 0; n < N; n++) begin : g_vec
    wire logic dma_line;
    wire logic [1:0] sel;
    // DMA lines bypass the routing fabric
    if (n < nvc_pkg::DMA_GRP) begin : g_lo
      assign dma_line = dma_terminal_out_low_group[n];
    end else begin : g_hi
      assign dma_line = dma_terminal_out_high_group[n - nvc_pkg::DMA_GRP];
    end
    assign sel = source_sel[2*n +: 2];
    // Array line may carry any routed signal, so any source reaches any vector
    assign src[n] = (sel == nvc_pkg::SRC_FIXED) ? fixed_irq[n] :
                    (sel == nvc_pkg::SRC_DMA) ? dma_line :
                    (sel == nvc_pkg::SRC_ARRAY) ? array_irq[n] : 1'b0;
  end
endmodule // nvc_src_sel

// ==== verilog/nvc_prio_arb.sv ====
// Lowest-level-wins arbiter; ties go to the lowest index.
// Assumes combinational use inside one clock domain.
module nvc_prio_arb #(
  parameter int N = 48,
  parameter int W = 4,
  parameter int IW = 6
) (
  input wire logic [N-1:0] req,
  input wire logic [N*W-1:0] prio,
  output logic found,
  output logic [IW-1:0] idx,
  output logic [W-1:0] level
);
  if (N < 2 || N > (1 << IW)) begin : g_bad_n
    $error("nvc_prio_arb: N does not fit index width");
  end

  // Scan downward with <= so an equal level at a lower index wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    level = '1;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && prio[i*W +: W] <= level) begin
        found = 1'b1;
        idx = IW'(i);
        level = prio[i*W +: W];
      end
    end
  end
endmodule // nvc_prio_arb

// ==== bench/nvc_checker.sv ====
// Port-level assertions for the nested vector controller.
// Assumes one clock domain with the synchronous active-high reset.
module nvc_checker #(
  parameter int NMI_PINS = 8,
  parameter int NMI_SEL_W = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [NMI_PINS-1:0] nmi_pins,
  input wire logic [NMI_SEL_W-1:0] nmi_pin_sel,
  input wire logic nmi_connect,
  input wire logic vec_ready,
  input wire logic [31:0] vec_data,
  input wire logic vec_fetch_q,
  input wire logic [nvc_pkg::AW-1:0] vec_addr_q,
  input wire logic sp_load_q,
  input wire logic [31:0] main_stack_pointer_q,
  input wire logic handler_start_q,
  input wire logic [31:0] handler_addr_q,
  input wire logic [nvc_pkg::IDX_W-1:0] exc_num_q,
  input wire logic stacking_q,
  input wire logic unstacking_q,
  input wire logic [nvc_pkg::N_EXC-1:0] pending_q,
  input wire logic [nvc_pkg::N_EXC-1:0] active_q
);
  wire logic nmi_line = nmi_connect & nmi_pins[nmi_pin_sel];
  wire logic take = vec_fetch_q & vec_ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_FETCH_HOLD: assert property (
    vec_fetch_q && !vec_ready |=> vec_fetch_q && $stable(vec_addr_q))
    else $error("fetch request dropped or moved before answer");
  AST_FETCH_ADDR: assert property (
    vec_fetch_q |-> vec_addr_q[1:0] == 2'h0 && vec_addr_q <= 10'h0BC)
    else $error("fetch offset outside the table");
  AST_SP_LOAD: assert property (
    take && vec_addr_q == 10'h000 |=> sp_load_q && main_stack_pointer_q == $past(vec_data))
    else $error("stack pointer not loaded from word zero");
  AST_HANDLER_ADDR: assert property (
    take && vec_addr_q != 10'h000 |=> handler_start_q
      && handler_addr_q == {$past(vec_data[31:1]), 1'h0}
      && exc_num_q == $past(vec_addr_q[7:2]))
    else $error("handler start does not match fetched entry");
  AST_STACK_LEN: assert property (
    $rose(stacking_q) |-> stacking_q [*8] ##1 !stacking_q)
    else $error("stacking not eight cycles");
  AST_UNSTACK_LEN: assert property (
    $rose(unstacking_q) |-> unstacking_q [*8] ##1 !unstacking_q)
    else $error("unstacking not eight cycles");
  AST_STACK_END: assert property (
    $fell(stacking_q) |-> vec_fetch_q || unstacking_q)
    else $error("stacking ended without fetch or unstack");
  AST_ENTRY_STATE: assert property (
    handler_start_q && exc_num_q != 6'h01 |-> active_q[exc_num_q] && !pending_q[exc_num_q])
    else $error("entered exception not active or still pending");
  AST_NMI_PEND: assert property (
    $rose(nmi_line) |=> pending_q[2])
    else $error("selected nmi pin rise did not pend");
endmodule // nvc_checker

bind nvc_ctrl nvc_checker #(.NMI_PINS(NMI_PINS), .NMI_SEL_W(NMI_SEL_W)) u_nvc_checker (
  .clk(clk), .srst(srst), .nmi_pins(nmi_pins), .nmi_pin_sel(nmi_pin_sel),
  .nmi_connect(nmi_connect), .vec_ready(vec_ready), .vec_data(vec_data),
  .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q), .sp_load_q(sp_load_q),
  .main_stack_pointer_q(main_stack_pointer_q), .handler_start_q(handler_start_q),
  .handler_addr_q(handler_addr_q), .exc_num_q(exc_num_q), .stacking_q(stacking_q),
  .unstacking_q(unstacking_q), .pending_q(pending_q), .active_q(active_q)
);

// ==== bench/nvc_vec_model.sv ====
// Vector table memory answering the controller's fetches.
// Assumes fetches are held until the ready pulse; dly adds wait cycles.
module nvc_vec_model #(
  parameter logic [31:0] SP_WORD = 32'h20007FF0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic vec_fetch_q,
  input wire logic [nvc_pkg::AW-1:0] vec_addr_q,
  input wire logic [3:0] dly,
  output logic vec_ready,
  output logic [31:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  initial begin
    vec_ready = 1'h0;
    vec_data = 32'h0;
    cnt = 4'h0;
  end
  always @(posedge clk) begin
    #1;
    if (srst || vec_ready) begin
      vec_ready = 1'h0;
      vec_data = ~vec_data;
      cnt = 4'h0;
    end else if (vec_fetch_q && cnt >= dly) begin
      vec_ready = 1'h1;
      vec_data = (vec_addr_q == 10'h000) ? SP_WORD : {22'h000101, vec_addr_q[9:1], 1'h1};
    end else if (vec_fetch_q) begin
      cnt = cnt + 4'h1;
    end else begin
      // Idle bus never holds one word for two cycles in a row
      vec_data = ~vec_data;
    end
  end
endmodule // nvc_vec_model

// ==== bench/testbench.sv ====
// Self-checking bench for the nested vector controller.
// Assumes the vector model answers fetches and the checker is bound.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SP_WORD = 32'h20007FF0;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [31:0] fixed_irq = '0, array_irq = '0, irq_enable = '0;
  logic [15:0] dma_lo = '0, dma_hi = '0;
  logic [63:0] source_sel = '1;
  logic [95:0] irq_priority = '0;
  logic [2:0] fault_enable = 3'h7, base_mask = 3'h0, nmi_sel = 3'h0;
  logic [7:0] nmi_pins = '0;
  logic nmi_connect = 1'h0, exc_return = 1'h0, vec_ready, seen_unst;
  logic [6:0] sys_ev = '0;
  logic [3:0] dly = 4'h0;
  logic [1:0] prio_grp = 2'h0;
  logic [31:0] vec_data, handler_addr_q, main_stack_pointer;
  logic vec_fetch_q, sp_load_q, handler_start_q, stacking_q, unstacking_q;
  logic [9:0] vec_addr_q;
  logic [5:0] exc_num_q;
  logic [47:0] pending_q, active_q;
  logic [3:0] running_level_q;
  logic [5:0] exc_tab [7] = '{6'h04, 6'h05, 6'h06, 6'h0B, 6'h0C, 6'h0E, 6'h0F};
  int n_errors = 0, n_compared = 0;
  always #50 clk = ~clk;

  nvc_ctrl u_nvc_ctrl (
    .clk(clk), .srst(srst), .fixed_irq(fixed_irq), .dma_terminal_out_low_group(dma_lo),
    .dma_terminal_out_high_group(dma_hi), .array_irq(array_irq), .source_sel(source_sel),
    .irq_enable(irq_enable), .irq_priority(irq_priority), .sys_priority(48'h0),
    .fault_enable(fault_enable), .priority_group(prio_grp), .base_priority_mask(base_mask),
    .primask(1'h0), .faultmask(1'h0), .nmi_pins(nmi_pins), .nmi_pin_sel(nmi_sel),
    .nmi_connect(nmi_connect), .nonexec_fetch(sys_ev[0]), .bus_error(sys_ev[1]),
    .invalid_instr(sys_ev[2]), .service_call(sys_ev[3]), .debug_monitor(sys_ev[4]),
    .deferred_service_request(sys_ev[5]), .system_tick_timer(sys_ev[6]),
    .exc_return(exc_return), .vec_ready(vec_ready), .vec_data(vec_data),
    .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q), .sp_load_q(sp_load_q),
    .main_stack_pointer_q(main_stack_pointer), .handler_start_q(handler_start_q),
    .handler_addr_q(handler_addr_q), .exc_num_q(exc_num_q), .stacking_q(stacking_q),
    .unstacking_q(unstacking_q), .pending_q(pending_q), .active_q(active_q),
    .running_level_q(running_level_q)
  );
  nvc_vec_model #(.SP_WORD(SP_WORD)) u_nvc_vec_model (
    .clk(clk), .srst(srst), .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q),
    .dly(dly), .vec_ready(vec_ready), .vec_data(vec_data)
  );

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_start();
    seen_unst = 1'h0;
    for (int i = 0; i < 80 && handler_start_q !== 1'h1; i++) begin
      tick(1);
      seen_unst |= unstacking_q;
    end
    chk("handler_start", 32'h1, {31'h0, handler_start_q});
  endtask
  task automatic enter(logic [5:0] exc);
    wait_start();
    chk("exc_num", {26'h0, exc}, {26'h0, exc_num_q});
    chk("handler_addr", {22'h000101, 2'h0, exc, 2'h0}, handler_addr_q);
  endtask
  task automatic leave();
    exc_return = 1'h1;
    tick(1);
    exc_return = 1'h0;
  endtask
  task automatic serve(logic [5:0] exc);
    enter(exc);
    leave();
  endtask
  task automatic idle();
    tick(11);
    chk("running_level", 32'hF, {28'h0, running_level_q});
  endtask
  task automatic set_src(int n, int m, logic v);
    if (m == 0) fixed_irq[n] = v;
    else if (m == 2) array_irq[n] = v;
    else if (n < 16) dma_lo[n] = v;
    else dma_hi[n-16] = v;
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(6000 * 100);
    n_errors++;
    conclude();
  end

  initial begin
    tick(6);
    srst = 1'h0;
    wait_start();
    chk("exc_num", 32'h1, {26'h0, exc_num_q});
    chk("reset_entry", {22'h000101, 10'h004}, handler_addr_q);
    chk("stack_ptr", SP_WORD, main_stack_pointer);
    $display("test boot done");
    for (int k = 0; k < 7; k++) begin
      dly = 4'(k);
      sys_ev[k] = 1'h1;
      tick(1);
      sys_ev[k] = 1'h0;
      serve(exc_tab[k]);
      idle();
    end
    dly = 4'h0;
    fault_enable = 3'h0;
    sys_ev[1] = 1'h1;
    tick(1);
    sys_ev[1] = 1'h0;
    serve(6'h03);
    idle();
    fault_enable = 3'h7;
    $display("test system exceptions done");
    irq_enable = '1;
    for (int n = 3; n < 32; n += 17) begin
      for (int m = 0; m < 3; m++) begin
        source_sel[2*n+:2] = m[1:0];
        for (int o = 0; o < 3; o++) if (o != m) set_src(n, o, 1'h1);
        tick(4);
        chk("unselected_pend", 32'h0, {31'h0, pending_q[16+n]});
        set_src(n, m, 1'h1);
        serve(6'(16 + n));
        idle();
        for (int o = 0; o < 3; o++) set_src(n, o, 1'h0);
      end
    end
    $display("test source select done");
    source_sel[14+:2] = 2'h0;
    source_sel[18+:2] = 2'h0;
    irq_priority[21+:3] = 3'h2;
    irq_priority[27+:3] = 3'h2;
    fixed_irq[9] = 1'h1;
    fixed_irq[7] = 1'h1;
    serve(6'h17);
    serve(6'h19);
    chk("unstack_between", 32'h0, {31'h0, seen_unst});
    idle();
    fixed_irq = '0;
    $display("test tie and tail chain done");
    source_sel[10+:2] = 2'h0;
    irq_priority[15+:3] = 3'h4;
    base_mask = 3'h4;
    fixed_irq[5] = 1'h1;
    tick(20);
    chk("masked_wait", 32'h1, {31'h0, pending_q[21] & ~active_q[21]});
    base_mask = 3'h5;
    serve(6'h15);
    chk("mask_level", 32'h7, {28'h0, running_level_q});
    idle();
    base_mask = 3'h0;
    fixed_irq = '0;
    $display("test base mask done");
    // Let the falling sources be seen before raising them again
    tick(2);
    fixed_irq[5] = 1'h1;
    enter(6'h15);
    fixed_irq[7] = 1'h1;
    tick(1);
    serve(6'h17);
    chk("nested_level", 32'h5, {28'h0, running_level_q});
    tick(11);
    chk("outer_level", 32'h7, {28'h0, running_level_q});
    leave();
    idle();
    fixed_irq = '0;
    prio_grp = 2'h3;
    tick(2);
    fixed_irq[5] = 1'h1;
    enter(6'h15);
    fixed_irq[7] = 1'h1;
    tick(20);
    chk("sublevel_wait", 32'h1, {31'h0, pending_q[23] & ~active_q[23]});
    leave();
    enter(6'h17);
    chk("chain_no_unstack", 32'h0, {31'h0, seen_unst});
    leave();
    idle();
    fixed_irq = '0;
    prio_grp = 2'h0;
    $display("test grouping done");
    nmi_sel = 3'h5;
    nmi_connect = 1'h1;
    nmi_pins = 8'h10;
    tick(3);
    chk("nmi_unselected", 32'h0, {31'h0, pending_q[2]});
    nmi_pins = 8'h30;
    serve(6'h02);
    chk("nmi_level", 32'h1, {28'h0, running_level_q});
    idle();
    $display("test nmi done");
    conclude();
  end
endmodule // testbench
